// ===== core/ebp_params.svh
// Purpose: Constants for the external bus port
// Assumes: 100 MHz mclk_in
// Notes:   Included by every design file of the port
`ifndef EBP_PARAMS_SVH
`define EBP_PARAMS_SVH

`define EBP_BUS_W        16
`define EBP_BYTE_W       8
`define EBP_LVL_W        6
`define EBP_FIFO_DEPTH   32
`define EBP_WAIT_CYCLES  2
`define EBP_CLK_DIV      4
`define EBP_STRB_CYCLES  3'h5
`define EBP_ONE_LVL      6'h01
`define EBP_TWO_LVL      6'h02
`define EBP_ZERO_BYTE    8'h00
`define EBP_ZERO_WORD    16'h0000

`endif

// ===== core/ebp_pkg.sv
// Purpose: Types shared by the external bus port
// Assumes: ebp_params.svh defines widths
// Notes:   Types only, no constants
`include "ebp_params.svh"
package ebp_pkg;

    // One-hot master transfer states
    typedef enum logic [4:0] {
        EBP_IDLE  = 5'b0_0001,
        EBP_SETUP = 5'b0_0010,
        EBP_STRB  = 5'b0_0100,
        EBP_HOLD  = 5'b0_1000,
        EBP_DONE  = 5'b1_0000
    } ebp_state_t;

    // Pin bundle for the two-way data bus
    typedef struct packed {
        logic [`EBP_BUS_W-1:0] data;
        logic                  oe;
    } ebp_bus_t;

    // Word stream between port and fifos
    typedef struct packed {
        logic [`EBP_BUS_W-1:0] data;
        logic                  valid;
    } ebp_word_t;

endpackage

// ===== core/ebp_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: One clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
`include "ebp_params.svh"
module ebp_sync3 import ebp_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    input  wire logic         ce_in,
    // Pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } ebp_sync_t;

    ebp_sync_t r;
    ebp_sync_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = pin_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // Change accepted once two late stages agree
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                next_r.lvl[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign level_out = r.lvl;
endmodule // ebp_sync3
`default_nettype wire

// ===== core/ebp_fifo.sv
// Purpose: Flip-flop fifo with fill level
// Assumes: Single clock
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
`include "ebp_params.svh"
module ebp_fifo import ebp_pkg::*; #(
    parameter int W = `EBP_BUS_W,
    parameter int D = `EBP_FIFO_DEPTH,
    parameter int A = $clog2(D)
) (
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    input  wire logic         ce_in,
    // Write side
    input  wire logic         wr_in,
    input  wire logic [W-1:0] wdata_in,
    // Read side
    input  wire logic         rd_in,
    output logic      [W-1:0] rdata_out,
    // Status
    output logic      [A:0]   level_out
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [A-1:0]        wp;
        logic [A-1:0]        rp;
        logic [A:0]          lvl;
    } ebp_fifo_st_t;

    ebp_fifo_st_t r;
    ebp_fifo_st_t next_r;
    logic         do_wr;
    logic         do_rd;

    always_comb begin
        next_r = r;
        // Overflow and underflow are dropped, never wrapped
        do_wr  = wr_in && (r.lvl != (A+1)'(D));
        do_rd  = rd_in && (r.lvl != '0);
        if (do_wr) begin
            next_r.mem[r.wp] = wdata_in;
            next_r.wp        = r.wp + 1'b1;
        end
        if (do_rd) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.lvl = r.lvl + (A+1)'(do_wr) - (A+1)'(do_rd);
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign rdata_out = r.mem[r.rp];
    assign level_out = r.lvl;
endmodule // ebp_fifo
`default_nettype wire

// ===== core/ebp_port.sv
// Purpose: Parallel external bus port, master or slave, 8 or 16 bit
// Assumes: Pins synchronised here; fifo user side on mclk_in
// Notes:   Master strobes the far slave; slave follows the far master
// ======================================================================
// Notes on behaviour
// R1: Data width is selectable between 8 and 16 bits and data lines are two-way.
// R2: Sixteen data lines are driven on outgoing and sampled on incoming transfers.
// R3: Direction line is an input in slave mode and driven by the port as master.
// R4: The bus master drives direction high for writes and low for reads.
// R5: As master the port drives a read enable so the far slave returns data.
// R6: As slave the read enable is unused and held high.
// R7: Read request is high while the transmit fifo holds one access worth of data.
// R8: Receive full is high while the receive fifo level reaches its watermark.
// R9: Active low wait holds an access until data is ready or accepted.
// R10: One two-way line carries bus clock as master or chip select as slave.
// R11: In 8-bit mode only the low eight lines carry data; upper lines idle low.
`timescale 1ns/1ps
`default_nettype none
`include "ebp_params.svh"
module ebp_port import ebp_pkg::*; #(
    parameter int BUS_W = `EBP_BUS_W,
    parameter int DEPTH = `EBP_FIFO_DEPTH,
    parameter int LVL_W = `EBP_LVL_W
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,

    // Configuration
    input  wire logic             master_mode_in,
    input  wire logic             wide_mode_in,
    input  wire logic [LVL_W-1:0] rx_watermark_in,

    // Master access request
    input  wire logic             m_start_in,
    input  wire logic             m_write_in,

    // Transmit fifo fill side
    input  wire logic             tx_push_in,
    input  wire logic [BUS_W-1:0] tx_data_in,

    // Receive fifo drain side
    input  wire logic             rx_pop_in,
    output logic      [BUS_W-1:0] rx_data_out,
    output logic      [LVL_W-1:0] rx_level_out,

    // Data pins
    input  wire logic [BUS_W-1:0] port_data_bus_in,
    output logic      [BUS_W-1:0] port_data_bus_out,
    output logic                  port_data_bus_oe_out,

    // Clock or select pin
    input  wire logic             port_clock_or_select_in,
    output logic                  port_clock_or_select_out,
    output logic                  port_clock_or_select_oe_out,

    // Direction pin
    input  wire logic             transfer_direction_in,
    output logic                  transfer_direction_out,
    output logic                  transfer_direction_oe_out,

    // Wait pin, active low, two-way
    input  wire logic             wait_n_in,
    output logic                  wait_n_out,
    output logic                  wait_n_oe_out,

    // Status pins
    output logic                  read_enable_out,
    output logic                  read_request_out,
    output logic                  receive_full_flag_out,
    output logic                  m_done_out
);
    typedef struct packed {
        ebp_state_t            st;
        logic [BUS_W-1:0]      dout;
        logic                  doe;
        logic                  ck;
        logic                  ckoe;
        logic                  dir;
        logic                  diroe;
        logic                  rden;
        logic                  wt;
        logic                  wtoe;
        logic                  rreq;
        logic                  rxf;
        logic                  done;
        logic [2:0]            cnt;
        logic                  armed;
        logic                  sel_d;
        logic [LVL_W-1:0]      rxl;
        logic [BUS_W-1:0]      rxd;
    } ebp_port_st_t;

    ebp_port_st_t     r;
    ebp_port_st_t     next_r;

    logic [BUS_W-1:0] din;
    logic [2:0]       pins;
    logic             sel_n;
    logic             dir_s;
    logic             wait_s;

    logic             tx_pop;
    logic             rx_push;
    logic [BUS_W-1:0] rx_word;
    logic [BUS_W-1:0] tx_word;
    logic [LVL_W-1:0] tx_lvl;
    logic [LVL_W-1:0] rx_lvl;
    logic [BUS_W-1:0] rx_head;
    logic [LVL_W-1:0] need;
    logic [BUS_W-1:0] tx_lane;
    logic [2:0]       pins_raw;

    // ==================================================================
    // Pin synchronisers
    ebp_sync3 #(.W(BUS_W)) u_dsync (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .pin_in    (port_data_bus_in),
        .level_out (din)
    );

    ebp_sync3 #(.W(3)) u_csync (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .pin_in    (pins_raw),
        .level_out (pins)
    );
    assign pins_raw = {port_clock_or_select_in, transfer_direction_in, wait_n_in};
    assign sel_n  = pins[2];
    assign dir_s  = pins[1];
    assign wait_s = pins[0];

    // ==================================================================
    // Fifos
    ebp_fifo #(.W(BUS_W), .D(DEPTH), .A(LVL_W-1)) u_txf (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .wr_in     (tx_push_in),
        .wdata_in  (tx_data_in),
        .rd_in     (tx_pop),
        .rdata_out (tx_word),
        .level_out (tx_lvl)
    );

    ebp_fifo #(.W(BUS_W), .D(DEPTH), .A(LVL_W-1)) u_rxf (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .wr_in     (rx_push),
        .wdata_in  (rx_word),
        .rd_in     (rx_pop_in),
        .rdata_out (rx_head),
        .level_out (rx_lvl)
    );

    // One access moves one fifo word in either width
    assign need    = `EBP_ONE_LVL;
    // Upper lines ignored in 8-bit mode
    assign rx_word = wide_mode_in ? din : {`EBP_ZERO_BYTE, din[`EBP_BYTE_W-1:0]}; // see R11
    // Outgoing word, upper byte idle in 8-bit mode
    assign tx_lane = wide_mode_in ? tx_word : {`EBP_ZERO_BYTE, tx_word[`EBP_BYTE_W-1:0]};

    // ==================================================================
    // Transfer control
    always_comb begin
        next_r      = r;
        tx_pop      = 1'b0;
        rx_push     = 1'b0;
        next_r.done = 1'b0;
        next_r.sel_d = sel_n;
        next_r.rxl  = rx_lvl;
        next_r.rxd  = rx_head;

        next_r.rreq = (tx_lvl >= need); // see R7
        next_r.rxf  = (rx_lvl >= rx_watermark_in); // see R8

        if (master_mode_in) begin
            // Master owns direction, clock and read enable
            next_r.diroe = 1'b1; // see R3
            next_r.ckoe  = 1'b1; // see R10
            next_r.wtoe  = 1'b0;
            next_r.wt    = 1'b1;
            // Slave side must see select high before its first access
            next_r.armed = 1'b0;

            unique case (r.st)
                EBP_IDLE: begin
                    next_r.ck   = 1'b0;
                    next_r.rden = 1'b1;
                    next_r.doe  = 1'b0;
                    if (m_start_in && (!m_write_in || tx_lvl >= need)) begin
                        next_r.dir = m_write_in; // see R4
                        next_r.st  = EBP_SETUP;
                        if (m_write_in) begin
                            next_r.doe  = 1'b1; // see R2
                            next_r.dout = tx_lane; // see R11
                            tx_pop      = 1'b1;
                        end
                    end
                end

                EBP_SETUP: begin
                    next_r.ck   = 1'b1;
                    next_r.rden = r.dir; // see R5
                    next_r.cnt  = 3'h0;
                    next_r.st   = EBP_STRB;
                end

                EBP_STRB: begin
                    // Strobe outlasts the pin sync so read data has settled
                    if (r.cnt != `EBP_STRB_CYCLES) begin
                        next_r.cnt = r.cnt + 3'h1;
                    end else if (wait_s) begin // see R9
                        // Far slave stretches the strobe with wait
                        next_r.st = EBP_HOLD;
                        if (!r.dir) begin
                            rx_push = 1'b1; // see R2
                        end
                    end
                end

                EBP_HOLD: begin
                    next_r.ck   = 1'b0;
                    next_r.rden = 1'b1;
                    next_r.st   = EBP_DONE;
                end

                EBP_DONE: begin
                    next_r.doe  = 1'b0;
                    next_r.dir  = 1'b0;
                    next_r.done = 1'b1;
                    next_r.st   = EBP_IDLE;
                end

                default: begin
                    next_r.st = EBP_IDLE;
                end
            endcase
        end else begin
            // Slave: direction and select come from the far master
            next_r.st    = EBP_IDLE;
            next_r.diroe = 1'b0; // see R3
            next_r.ckoe  = 1'b0; // see R10
            next_r.ck    = 1'b1;
            next_r.rden  = 1'b1; // see R6
            // Stale low select from a mode switch is no access
            next_r.armed = r.armed || sel_n;
            next_r.wtoe  = r.armed && !sel_n;
            next_r.doe   = r.armed && !sel_n && !dir_s; // see R4

            // Wait low until the word is ready or room exists
            next_r.wt    = dir_s ? (rx_lvl != LVL_W'(DEPTH)) : (tx_lvl >= need); // see R9
            if (!r.doe && !dir_s && !sel_n) begin
                next_r.dout = tx_lane; // see R11
            end

            // Access ends on select release
            if (r.armed && sel_n && !r.sel_d) begin
                if (dir_s) begin
                    rx_push = 1'b1; // see R2
                end else begin
                    tx_pop = 1'b1;
                end
                next_r.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            r       <= '0;
            r.st    <= EBP_IDLE;
            // Active low pins idle high
            r.rden  <= 1'b1;
            r.wt    <= 1'b1;
            r.sel_d <= 1'b1;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    // ==================================================================
    // Outputs, all from flip-flops
    assign port_data_bus_out           = r.dout;
    assign port_data_bus_oe_out        = r.doe; // see R1
    assign port_clock_or_select_out    = r.ck;
    assign port_clock_or_select_oe_out = r.ckoe;
    assign transfer_direction_out      = r.dir;
    assign transfer_direction_oe_out   = r.diroe;
    assign wait_n_out                  = r.wt;
    assign wait_n_oe_out               = r.wtoe;
    assign read_enable_out             = r.rden;
    assign read_request_out            = r.rreq;
    assign receive_full_flag_out       = r.rxf;
    assign m_done_out                  = r.done;
    // Head and level lag the fifo by one cycle
    assign rx_data_out                 = r.rxd;
    assign rx_level_out                = r.rxl;
endmodule // ebp_port
`default_nettype wire

// ===== verif/ebp_port_chk.sv
// Purpose: Port-level assertions for ebp_port
// Assumes: One clock, async reset high
// Notes:   Mode inputs change only between accesses
`timescale 1ns/1ps
`default_nettype none
module ebp_port_chk #(
    parameter int BUS_W = 16,
    parameter int LVL_W = 6
) (
    // Clock, reset and configuration
    input wire logic             mclk_in,
    input wire logic             rst_in,
    input wire logic             master_mode_in,
    input wire logic             wide_mode_in,
    input wire logic [LVL_W-1:0] rx_watermark_in,
    // Observed outputs
    input wire logic [LVL_W-1:0] rx_level_out,
    input wire logic [BUS_W-1:0] port_data_bus_out,
    input wire logic             port_data_bus_oe_out,
    input wire logic             port_clock_or_select_oe_out,
    input wire logic             transfer_direction_out,
    input wire logic             transfer_direction_oe_out,
    input wire logic             wait_n_oe_out,
    input wire logic             read_enable_out,
    input wire logic             receive_full_flag_out,
    input wire logic             m_done_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // ==================================================================
    // Checks
    slave_rden_a: assert property (!master_mode_in && $past(!master_mode_in)
        |-> read_enable_out) else $error("read enable active in slave mode");
    slave_dir_a: assert property (!master_mode_in && $past(!master_mode_in)
        |-> !transfer_direction_oe_out) else $error("direction driven as slave");
    slave_clk_a: assert property (!master_mode_in && $past(!master_mode_in)
        |-> !port_clock_or_select_oe_out) else $error("clock pin driven as slave");
    master_wait_a: assert property (master_mode_in && $past(master_mode_in)
        |-> !wait_n_oe_out) else $error("wait driven as master");
    read_dir_a: assert property (!read_enable_out
        |-> transfer_direction_oe_out && !transfer_direction_out) else $error("read dir wrong");
    read_float_a: assert property (!read_enable_out
        |-> !port_data_bus_oe_out) else $error("bus driven during read");
    narrow_bus_a: assert property (port_data_bus_oe_out && !wide_mode_in
        |-> port_data_bus_out[15:8] == 8'h00) else $error("upper lines active");
    full_flag_a: assert property (rx_level_out == $past(rx_level_out)
        && rx_watermark_in == $past(rx_watermark_in)
        |-> receive_full_flag_out == (rx_level_out >= rx_watermark_in)) else $error("full flag");
    done_pulse_a: assert property (m_done_out |=> !m_done_out)
        else $error("done longer than one cycle");
    strobe_end_a: assert property ($fell(read_enable_out) |-> ##[1:60] m_done_out)
        else $error("read never completed");
    cover property (m_done_out && transfer_direction_out);
    cover property (!read_enable_out);
    cover property ($rose(receive_full_flag_out));
endmodule // ebp_port_chk
bind ebp_port ebp_port_chk #(.BUS_W(BUS_W), .LVL_W(LVL_W)) u_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .master_mode_in(master_mode_in),
    .wide_mode_in(wide_mode_in), .rx_watermark_in(rx_watermark_in),
    .rx_level_out(rx_level_out), .port_data_bus_out(port_data_bus_out),
    .port_data_bus_oe_out(port_data_bus_oe_out),
    .port_clock_or_select_oe_out(port_clock_or_select_oe_out),
    .transfer_direction_out(transfer_direction_out),
    .transfer_direction_oe_out(transfer_direction_oe_out), .wait_n_oe_out(wait_n_oe_out),
    .read_enable_out(read_enable_out), .receive_full_flag_out(receive_full_flag_out),
    .m_done_out(m_done_out));
`default_nettype wire

// ===== verif/ebp_far_model.sv
// Purpose: Far party of the port, slave or master
// Assumes: Bench supplies the master-side pin levels
// Notes:   Released data lines wander, never hold old value
`timescale 1ns/1ps
`default_nettype none
module ebp_far_model (
    // Clock, reset and commands
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        far_master_in,
    input  wire logic        hold_wait_in,
    input  wire logic        ext_sel_n_in,
    input  wire logic        ext_dir_in,
    input  wire logic [15:0] rd_word_in,
    input  wire logic [15:0] ext_wdata_in,
    // Resolved pins
    input  wire logic [15:0] bus_in,
    input  wire logic        clk_in,
    input  wire logic        dir_in,
    input  wire logic        read_enable_in,
    // Driven levels
    output logic      [15:0] data_out,
    output logic             sel_out,
    output logic             dir_out,
    output logic             wait_n_out,
    output logic      [15:0] last_wr_out
);
    logic [15:0] idle;
    logic        clk_q;
    always_comb begin
        if (far_master_in && ext_dir_in) data_out = ext_wdata_in;
        else if (!far_master_in && !read_enable_in) data_out = rd_word_in;
        else data_out = idle;
    end
    assign sel_out    = ext_sel_n_in;
    assign dir_out    = ext_dir_in;
    assign wait_n_out = !hold_wait_in;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            idle        <= 16'h0000;
            clk_q       <= 1'b0;
            last_wr_out <= 16'h0000;
        end else begin
            idle  <= ~data_out;
            clk_q <= clk_in;
            if (!far_master_in && clk_in && !clk_q && dir_in) last_wr_out <= bus_in;
        end
    end
endmodule // ebp_far_model
`default_nettype wire

// ===== verif/ebp_port_tb.sv
// Purpose: Self-checking bench for ebp_port
// Assumes: 100 MHz clock, inputs driven 1 ns after rising edge
// Notes:   Far party modelled in ebp_far_model
`timescale 1ns/1ps
`default_nettype none
module ebp_port_tb;
    logic        mclk_in, rst_in, master_mode, wide_mode, m_start, m_write, tx_push, rx_pop;
    logic        hold_wait, ext_sel_n, ext_dir, p_sel, p_dir, p_wait;
    logic        bus_oe, cs_out, cs_oe, dir_out, dir_oe, w_out, w_oe, rd_en_n, rd_req, rx_full;
    logic        m_done;
    logic [15:0] tx_data, rd_word, ext_wdata, rx_data, bus_out, p_data, last_wr;
    logic [5:0]  rx_level, rx_wm;
    int          num_errors, cmp_count, cycles;
    wire  [15:0] bus_w  = bus_oe ? bus_out : p_data;
    wire         cs_w   = cs_oe ? cs_out : p_sel;
    wire         dir_w  = dir_oe ? dir_out : p_dir;
    wire         wait_w = w_oe ? w_out : p_wait;
    ebp_port DUT (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1),
        .master_mode_in(master_mode), .wide_mode_in(wide_mode), .rx_watermark_in(rx_wm),
        .m_start_in(m_start), .m_write_in(m_write), .tx_push_in(tx_push), .tx_data_in(tx_data),
        .rx_pop_in(rx_pop), .rx_data_out(rx_data), .rx_level_out(rx_level),
        .port_data_bus_in(bus_w), .port_data_bus_out(bus_out), .port_data_bus_oe_out(bus_oe),
        .port_clock_or_select_in(cs_w), .port_clock_or_select_out(cs_out),
        .port_clock_or_select_oe_out(cs_oe), .transfer_direction_in(dir_w),
        .transfer_direction_out(dir_out), .transfer_direction_oe_out(dir_oe),
        .wait_n_in(wait_w), .wait_n_out(w_out), .wait_n_oe_out(w_oe),
        .read_enable_out(rd_en_n), .read_request_out(rd_req),
        .receive_full_flag_out(rx_full), .m_done_out(m_done));
    ebp_far_model FAR (.mclk_in(mclk_in), .rst_in(rst_in), .far_master_in(!master_mode),
        .hold_wait_in(hold_wait), .ext_sel_n_in(ext_sel_n), .ext_dir_in(ext_dir),
        .rd_word_in(rd_word), .ext_wdata_in(ext_wdata), .bus_in(bus_w), .clk_in(cs_w),
        .dir_in(dir_w), .read_enable_in(rd_en_n), .data_out(p_data), .sel_out(p_sel),
        .dir_out(p_dir), .wait_n_out(p_wait), .last_wr_out(last_wr));
    // ==================================================================
    // Common tasks
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_done;
        for (int i = 0; i < 80 && m_done !== 1'b1; i++) step(1);
        chk("m_done", m_done, 16'h0001);
    endtask
    task automatic push(input logic [15:0] w);
        tx_data = w;
        tx_push = 1;
        step(1);
        tx_push = 0;
        step(3);
    endtask
    task automatic pop;
        rx_pop = 1;
        step(1);
        rx_pop = 0;
        step(2);
    endtask
    task automatic start(input logic wr);
        m_write = wr;
        m_start = 1;
        step(1);
        m_start = 0;
    endtask
    task automatic sw(input logic [15:0] w);
        ext_wdata = w;
        ext_dir = 1;
        ext_sel_n = 0;
        step(8);
        chk("s_wait", wait_w, 16'h0001);
        ext_sel_n = 1;
        step(6);
        ext_dir = 0;
        step(2);
    endtask
    // ==================================================================
    // Scenarios
    task automatic t_mwrite(input logic wide, input logic [15:0] w);
        wide_mode = wide;
        push(w);
        chk("rd_req", rd_req, 16'h0001);
        start(1);
        wait_done();
        step(2);
        chk("wr_data", last_wr, wide ? w : {8'h00, w[7:0]});
        chk("rd_req_low", rd_req, 16'h0000);
    endtask
    task automatic t_mread(input logic wide, input logic [15:0] w);
        wide_mode = wide;
        rd_word = w;
        start(0);
        wait_done();
        step(2);
        chk("rx_level", rx_level, 16'h0001);
        chk("rx_word", rx_data, wide ? w : {8'h00, w[7:0]});
        pop();
    endtask
    task automatic t_stall;
        int cnt;
        cnt = 0;
        wide_mode = 1;
        hold_wait = 1;
        push(16'h5A5A);
        start(1);
        repeat (15) begin
            if (m_done === 1'b1) cnt++;
            step(1);
        end
        chk("stall_done", 16'(cnt), 16'h0000);
        hold_wait = 0;
        wait_done();
        step(2);
        chk("stall_data", last_wr, 16'h5A5A);
    endtask
    task automatic t_slave_rx;
        sw(16'h1234);
        chk("full_lo", rx_full, 16'h0000);
        sw(16'hBEEF);
        chk("full_hi", rx_full, 16'h0001);
        chk("rx_head", rx_data, 16'h1234);
        pop();
        chk("rx_next", rx_data, 16'hBEEF);
        pop();
        chk("full_clr", rx_full, 16'h0000);
        wide_mode = 0;
        sw(16'hFF77);
        chk("rx_narrow", rx_data, 16'h0077);
        pop();
        wide_mode = 1;
    endtask
    task automatic t_slave_read;
        push(16'hC0DE);
        chk("s_req", rd_req, 16'h0001);
        ext_sel_n = 0;
        step(8);
        chk("s_bus", bus_w, 16'hC0DE);
        chk("s_ready", wait_w, 16'h0001);
        chk("s_rden", rd_en_n, 16'h0001);
        chk("s_dir_oe", dir_oe, 16'h0000);
        ext_sel_n = 1;
        step(8);
        chk("s_req_low", rd_req, 16'h0000);
        chk("s_bus_oe", bus_oe, 16'h0000);
        ext_sel_n = 0;
        step(8);
        chk("s_wait_empty", wait_w, 16'h0000);
        ext_sel_n = 1;
        step(8);
    endtask
    // ==================================================================
    // Clock, timeout and main sequence
    initial begin
        mclk_in = 0;
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        {num_errors, cmp_count, cycles} = '0;
        {m_start, m_write, tx_push, rx_pop, hold_wait, ext_dir} = '0;
        {tx_data, rd_word, ext_wdata} = '0;
        rst_in = 1;
        master_mode = 1;
        wide_mode = 1;
        ext_sel_n = 1;
        rx_wm = 6'h02;
        step(16);
        rst_in = 0;
        step(4);
        chk("rden_idle", rd_en_n, 16'h0001);
        t_mwrite(1, 16'hA5C3);
        t_mwrite(0, 16'hA5C3);
        t_mread(1, 16'h3C5A);
        t_mread(0, 16'h3C5A);
        t_stall();
        master_mode = 0;
        step(4);
        t_slave_rx();
        t_slave_read();
        stop_test();
    end
endmodule // ebp_port_tb
`default_nettype wire
